// >>> rtl/aec_engine_regs.sv
`timescale 1ns/1ps
// Contract
// - writing one to keystream-done set bit enables it; reads show enable state
// - writing one to crypt-done set bit enables it; zero does nothing
// - writing one to error set bit enables the deprecated error interrupt
// - writing one to keystream-done clear bit disables it; reads match set
// - writing one to crypt-done clear bit disables it; zero does nothing
// - writing one to error clear bit disables it; reads show state
// - read-only integrity result holds last decryption check, one passed, resets zero; code ignores checks finished while the engine is off
// - engine works only while enable field is two; resets to zero
module aec_engine_regs
   import aec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        keystreamDoneEvent,
   input  wire logic        cryptDoneEvent,
   input  wire logic        errorEvent,
   input  wire logic        integrityDone,
   input  wire logic        integrityPass,
   output logic             engineOn,
   output logic             irq
);

   // ==================================================
   // address decode, shared by both channels
   function automatic aec_sel_t regSel(input logic [11:0] addr);
      aec_sel_t sel;
      sel = AEC_SEL_NONE;
      case (addr)
         AEC_OFF_IRQ_SET:    sel = AEC_SEL_IRQ_SET;
         AEC_OFF_IRQ_CLR:    sel = AEC_SEL_IRQ_CLR;
         AEC_OFF_EVT_STATUS: sel = AEC_SEL_EVT_STATUS;
         AEC_OFF_INTEGRITY:  sel = AEC_SEL_INTEGRITY;
         AEC_OFF_ENABLE:     sel = AEC_SEL_ENABLE;
         default:            sel = AEC_SEL_NONE;
      endcase
      return sel;
   endfunction

   typedef enum logic {
      WR_COLLECT,
      WR_RESP
   } aec_wr_t;

   typedef enum logic {
      RD_IDLE,
      RD_DATA
   } aec_rd_t;

   // strobes and levels shared with the irq unit
   aec_evt_if ev ();

   aec_wr_t                 wrState_q;
   aec_rd_t                 rdState_q;
   logic                    awHeld_q;
   logic                    wHeld_q;
   logic [11:0]             awAddr_q;
   logic [31:0]             wData_q;
   logic [3:0]              wStrb_q;
   logic                    awReady_q;
   logic                    wReady_q;
   logic                    bValid_q;
   logic [1:0]              bResp_q;
   logic                    arReady_q;
   logic                    rValid_q;
   logic [31:0]             rData_q;
   logic [1:0]              rResp_q;
   logic [AEC_ENABLE_W-1:0] enable_q;
   logic                    engineOn_q;
   logic                    integrity_q;
   logic                    awFire;
   logic                    wFire;
   logic                    doWrite;
   logic                    lowLane;
   aec_sel_t                wrSel;
   aec_sel_t                rdSel;

   assign awFire  = s_axi_awvalid && awReady_q;
   assign wFire   = s_axi_wvalid && wReady_q;
   // a write completes once both halves are held
   assign doWrite = (wrState_q == WR_COLLECT) && awHeld_q && wHeld_q;
   // all fields sit in byte zero, so the other lanes are ignored
   assign lowLane = wStrb_q[0];
   assign wrSel   = regSel(awAddr_q);
   assign rdSel   = regSel(s_axi_araddr);

   // ==================================================
   // write channel
   always_ff @(posedge clk) begin
      if (rst) begin
         wrState_q <= WR_COLLECT;
         bValid_q  <= 1'b0;
         bResp_q   <= AEC_RESP_OKAY;
      end else begin
         case (wrState_q)
            WR_COLLECT: begin
               if (doWrite) begin
                  wrState_q <= WR_RESP;
                  bValid_q  <= 1'b1;
                  bResp_q   <= (wrSel == AEC_SEL_NONE) ? AEC_RESP_SLVERR : AEC_RESP_OKAY;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wrState_q <= WR_COLLECT;
                  bValid_q  <= 1'b0;
               end
            end
            default: begin
               wrState_q <= WR_COLLECT;
               bValid_q  <= 1'b0;
            end
         endcase
      end
   end

   // address and data taken in either order, each held until the write
   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_q  <= 1'b0;
         awAddr_q  <= 12'h000;
         awReady_q <= 1'b1;
      end else if (awFire) begin
         awHeld_q  <= 1'b1;
         awAddr_q  <= s_axi_awaddr;
         awReady_q <= 1'b0;
      end else if (doWrite) begin
         awHeld_q  <= 1'b0;
      end else if ((wrState_q == WR_RESP) && s_axi_bready) begin
         awReady_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wHeld_q  <= 1'b0;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         wReady_q <= 1'b1;
      end else if (wFire) begin
         wHeld_q  <= 1'b1;
         wData_q  <= s_axi_wdata;
         wStrb_q  <= s_axi_wstrb;
         wReady_q <= 1'b0;
      end else if (doWrite) begin
         wHeld_q  <= 1'b0;
      end else if ((wrState_q == WR_RESP) && s_axi_bready) begin
         wReady_q <= 1'b1;
      end
   end

   // ==================================================
   // one-cycle strobes into the irq unit
   always_comb begin
      ev.setBits = AEC_RST_EVT;
      ev.clrBits = AEC_RST_EVT;
      ev.ackBits = AEC_RST_EVT;
      if (doWrite && lowLane) begin
         case (wrSel)
            AEC_SEL_IRQ_SET:    ev.setBits = wData_q[AEC_NUM_EVT-1:0];
            AEC_SEL_IRQ_CLR:    ev.clrBits = wData_q[AEC_NUM_EVT-1:0];
            AEC_SEL_EVT_STATUS: ev.ackBits = wData_q[AEC_NUM_EVT-1:0];
            default: begin
               ev.setBits = AEC_RST_EVT;
            end
         endcase
      end
   end

   // events only count while the engine is switched on
   always_comb begin
      ev.evtPulse = AEC_RST_EVT;
      if (engineOn_q) begin
         ev.evtPulse[AEC_BIT_KEYSTREAM] = keystreamDoneEvent;
         ev.evtPulse[AEC_BIT_CRYPT]     = cryptDoneEvent;
         ev.evtPulse[AEC_BIT_ERROR]     = errorEvent;
      end
   end

   aec_irq_unit u_irq (
      .clk (clk),
      .rst (rst),
      .ev  (ev)
   );

   // ==================================================
   // engine enable, full field stored so readback is exact
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_q <= AEC_ENABLE_OFF;
      end else if (doWrite && lowLane && (wrSel == AEC_SEL_ENABLE)) begin
         enable_q <= wData_q[AEC_ENABLE_W-1:0];
      end
   end

   // only the exact value two runs; other codes keep it stopped
   always_ff @(posedge clk) begin
      if (rst) begin
         engineOn_q <= 1'b0;
      end else begin
         engineOn_q <= (enable_q == AEC_ENABLE_ON);
      end
   end

   // ==================================================
   // integrity result, updated only by a finished check
   always_ff @(posedge clk) begin
      if (rst) begin
         integrity_q <= AEC_INTEGRITY_FAILED;
      end else if (engineOn_q && integrityDone) begin
         integrity_q <= integrityPass ? AEC_INTEGRITY_PASSED : AEC_INTEGRITY_FAILED;
      end
   end

   // ==================================================
   // read channel, data one cycle after the address
   always_ff @(posedge clk) begin
      if (rst) begin
         rdState_q <= RD_IDLE;
         arReady_q <= 1'b1;
         rValid_q  <= 1'b0;
         rData_q   <= 32'h0000_0000;
         rResp_q   <= AEC_RESP_OKAY;
      end else begin
         case (rdState_q)
            RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rdState_q <= RD_DATA;
                  arReady_q <= 1'b0;
                  rValid_q  <= 1'b1;
                  rResp_q   <= AEC_RESP_OKAY;
                  rData_q   <= 32'h0000_0000;
                  case (rdSel)
                     AEC_SEL_IRQ_SET,
                     AEC_SEL_IRQ_CLR: begin
                        rData_q[AEC_NUM_EVT-1:0] <= ev.enBits;
                     end
                     AEC_SEL_EVT_STATUS: begin
                        rData_q[AEC_NUM_EVT-1:0] <= ev.flagBits;
                     end
                     AEC_SEL_INTEGRITY: begin
                        rData_q[AEC_BIT_INTEGRITY] <= integrity_q;
                     end
                     AEC_SEL_ENABLE: begin
                        rData_q[AEC_ENABLE_W-1:0] <= enable_q;
                     end
                     default: begin
                        // unmapped: data stays zero, only the code flags it
                        rResp_q <= AEC_RESP_SLVERR;
                     end
                  endcase
               end
            end
            RD_DATA: begin
               if (s_axi_rready) begin
                  rdState_q <= RD_IDLE;
                  arReady_q <= 1'b1;
                  rValid_q  <= 1'b0;
               end
            end
            default: begin
               rdState_q <= RD_IDLE;
               arReady_q <= 1'b1;
               rValid_q  <= 1'b0;
            end
         endcase
      end
   end

   // ==================================================
   // outputs
   assign s_axi_awready = awReady_q;
   assign s_axi_wready  = wReady_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;
   assign engineOn      = engineOn_q;
   assign irq           = ev.irqLevel;
endmodule

// >>> rtl/aec_pkg.sv
package aec_pkg;
   // ==================================================
   // register map, byte addresses
   localparam logic [11:0] AEC_OFF_IRQ_SET    = 12'h304;
   localparam logic [11:0] AEC_OFF_IRQ_CLR    = 12'h308;
   localparam logic [11:0] AEC_OFF_EVT_STATUS = 12'h30c;
   localparam logic [11:0] AEC_OFF_INTEGRITY  = 12'h400;
   localparam logic [11:0] AEC_OFF_ENABLE     = 12'h500;

   // ==================================================
   // field layout
   localparam int AEC_NUM_EVT          = 3;
   localparam int AEC_BIT_KEYSTREAM    = 0;
   localparam int AEC_BIT_CRYPT        = 1;
   localparam int AEC_BIT_ERROR        = 2;
   localparam int AEC_BIT_INTEGRITY    = 0;
   localparam int AEC_ENABLE_W         = 2;

   // ==================================================
   // values
   localparam logic [AEC_NUM_EVT-1:0]  AEC_RST_EVT       = 3'h0;
   localparam logic [AEC_ENABLE_W-1:0] AEC_ENABLE_OFF    = 2'h0;
   localparam logic [AEC_ENABLE_W-1:0] AEC_ENABLE_ON     = 2'h2;
   localparam logic                    AEC_INTEGRITY_FAILED = 1'b0;
   localparam logic                    AEC_INTEGRITY_PASSED = 1'b1;
   localparam logic [1:0]              AEC_RESP_OKAY     = 2'h0;
   localparam logic [1:0]              AEC_RESP_SLVERR   = 2'h2;

   typedef enum logic [2:0] {
      AEC_SEL_IRQ_SET,
      AEC_SEL_IRQ_CLR,
      AEC_SEL_EVT_STATUS,
      AEC_SEL_INTEGRITY,
      AEC_SEL_ENABLE,
      AEC_SEL_NONE
   } aec_sel_t;
endpackage

// >>> rtl/aec_evt_if.sv
`timescale 1ns/1ps
interface aec_evt_if;
   logic [2:0] evtPulse;
   logic [2:0] setBits;
   logic [2:0] clrBits;
   logic [2:0] ackBits;
   logic [2:0] enBits;
   logic [2:0] flagBits;
   logic       irqLevel;

   modport regs (
      output evtPulse,
      output setBits,
      output clrBits,
      output ackBits,
      input  enBits,
      input  flagBits,
      input  irqLevel
   );

   modport irq (
      input  evtPulse,
      input  setBits,
      input  clrBits,
      input  ackBits,
      output enBits,
      output flagBits,
      output irqLevel
   );
endinterface

// >>> rtl/aec_irq_unit.sv
`timescale 1ns/1ps
module aec_irq_unit
   import aec_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   aec_evt_if.irq    ev
);
   logic [AEC_NUM_EVT-1:0] enable_q;
   logic [AEC_NUM_EVT-1:0] flag_q;
   logic                   irq_q;

   // ==================================================
   // enable mask, set and clear live at separate addresses
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_q <= AEC_RST_EVT;
      end else begin
         enable_q <= (enable_q | ev.setBits) & ~ev.clrBits;
      end
   end

   // ==================================================
   // sticky flags; an event in the ack cycle survives
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= AEC_RST_EVT;
      end else begin
         flag_q <= (flag_q & ~ev.ackBits) | ev.evtPulse;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & enable_q);
      end
   end

   assign ev.enBits   = enable_q;
   assign ev.flagBits = flag_q;
   assign ev.irqLevel = irq_q;
endmodule

// >>> dv/aec_engine_regs_props.sv
`timescale 1ns/1ps
module aec_engine_regs_props
   import aec_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       engineOn,
   input wire logic       irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==================================================
   // bus handshakes
   reset_idle_a: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !irq && !engineOn)
      else $error("outputs not idle after reset");
   read_lock_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released");
   write_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not released");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   // ==================================================
   // engine and interrupt
   // engineOn and a falling irq lag a register write, so such a change needs a write just before; irq may also rise from an event
   engine_write_a: assert property ($changed(engineOn) |-> $past(s_axi_bvalid))
      else $error("engine changed without write");
   irq_cause_a: assert property ($rose(irq) |-> $past(s_axi_bvalid) || $past(engineOn, 2))
      else $error("irq rose without cause");
   irq_drop_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
      else $error("irq fell without write");
   cover property ($rose(irq));
   cover property ($rose(engineOn));
   cover property (s_axi_bvalid && s_axi_bresp == AEC_RESP_SLVERR);
endmodule

bind aec_engine_regs aec_engine_regs_props props (.*);

// >>> dv/aec_engine_regs_tb.sv
`timescale 1ns/1ps
module aec_engine_regs_tb
   import aec_pkg::*;
;
   logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, engineOn, irq;
   logic        keystreamDoneEvent, cryptDoneEvent, errorEvent, integrityDone, integrityPass;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          errorCnt, nCompared;
   localparam logic [11:0] REGS [5] = '{AEC_OFF_IRQ_SET, AEC_OFF_IRQ_CLR, AEC_OFF_EVT_STATUS,
                                        AEC_OFF_INTEGRITY, AEC_OFF_ENABLE};

   aec_engine_regs dut (.*);

   // ==================================================
   // access tasks
   task automatic finalReport;
      if (errorCnt == 0 && nCompared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      nCompared++;
      if (s !== e) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // bready stays low for one cycle so the response must hold
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge clk);
      chk($sformatf("bresp %h", a), 32'(s_axi_bresp), 32'(r));
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      chk($sformatf("rdata %h", a), s_axi_rdata, e);
      chk($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(r));
   endtask

   task automatic pulse(input logic [2:0] e, input logic d, input logic p);
      {errorEvent, cryptDoneEvent, keystreamDoneEvent} <= e;
      integrityDone <= d;
      integrityPass <= p;
      @(posedge clk);
      {errorEvent, cryptDoneEvent, keystreamDoneEvent} <= 3'h0;
      integrityDone <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ==================================================
   // clock, watchdog, tests
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (5000) @(posedge clk);
      errorCnt++;
      finalReport;
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {keystreamDoneEvent, cryptDoneEvent, errorEvent, integrityDone, integrityPass} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      // read side never stalls; write side exercises bready
      s_axi_rready = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      foreach (REGS[i]) rdchk(REGS[i], 32'h0, AEC_RESP_OKAY);
      rdchk(12'h010, 32'h0, AEC_RESP_SLVERR);
      wr(12'h010, 32'h7, AEC_RESP_SLVERR);
      for (int i = 0; i < 3; i++) begin
         wr(AEC_OFF_IRQ_SET, 32'h1 << i, AEC_RESP_OKAY);
         rdchk(AEC_OFF_IRQ_SET, (32'h2 << i) - 1, AEC_RESP_OKAY);
      end
      wr(AEC_OFF_IRQ_SET, 32'h0, AEC_RESP_OKAY);
      wr(AEC_OFF_IRQ_CLR, 32'h0, AEC_RESP_OKAY);
      rdchk(AEC_OFF_IRQ_CLR, 32'h7, AEC_RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         wr(AEC_OFF_IRQ_CLR, 32'h1 << i, AEC_RESP_OKAY);
         rdchk(AEC_OFF_IRQ_SET, 32'h7 & ~((32'h2 << i) - 1), AEC_RESP_OKAY);
      end
      s_axi_wstrb <= 4'h0;
      wr(AEC_OFF_IRQ_SET, 32'h7, AEC_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rdchk(AEC_OFF_IRQ_SET, 32'h0, AEC_RESP_OKAY);
      pulse(3'h7, 1'b1, 1'b1);
      rdchk(AEC_OFF_EVT_STATUS, 32'h0, AEC_RESP_OKAY);
      rdchk(AEC_OFF_INTEGRITY, 32'h0, AEC_RESP_OKAY);
      wr(AEC_OFF_ENABLE, 32'h1, AEC_RESP_OKAY);
      rdchk(AEC_OFF_ENABLE, 32'h1, AEC_RESP_OKAY);
      chk("engineOn", 32'(engineOn), 32'h0);
      wr(AEC_OFF_ENABLE, 32'(AEC_ENABLE_ON), AEC_RESP_OKAY);
      @(posedge clk);
      chk("engineOn", 32'(engineOn), 32'h1);
      pulse(3'h0, 1'b1, AEC_INTEGRITY_PASSED);
      rdchk(AEC_OFF_INTEGRITY, 32'h1, AEC_RESP_OKAY);
      wr(AEC_OFF_INTEGRITY, 32'h0, AEC_RESP_OKAY);
      rdchk(AEC_OFF_INTEGRITY, 32'h1, AEC_RESP_OKAY);
      pulse(3'h0, 1'b1, AEC_INTEGRITY_FAILED);
      rdchk(AEC_OFF_INTEGRITY, 32'h0, AEC_RESP_OKAY);
      wr(AEC_OFF_IRQ_SET, 32'h2, AEC_RESP_OKAY);
      pulse(3'h1, 1'b0, 1'b0);
      chk("irq", 32'(irq), 32'h0);
      rdchk(AEC_OFF_EVT_STATUS, 32'h1, AEC_RESP_OKAY);
      pulse(3'h2, 1'b0, 1'b0);
      chk("irq", 32'(irq), 32'h1);
      wr(AEC_OFF_IRQ_CLR, 32'h2, AEC_RESP_OKAY);
      chk("irq", 32'(irq), 32'h0);
      wr(AEC_OFF_IRQ_SET, 32'h4, AEC_RESP_OKAY);
      pulse(3'h4, 1'b0, 1'b0);
      chk("irq", 32'(irq), 32'h1);
      wr(AEC_OFF_IRQ_CLR, 32'h4, AEC_RESP_OKAY);
      chk("irq", 32'(irq), 32'h0);
      rdchk(AEC_OFF_EVT_STATUS, 32'h7, AEC_RESP_OKAY);
      wr(AEC_OFF_EVT_STATUS, 32'h7, AEC_RESP_OKAY);
      rdchk(AEC_OFF_EVT_STATUS, 32'h0, AEC_RESP_OKAY);
      wr(AEC_OFF_ENABLE, 32'(AEC_ENABLE_OFF), AEC_RESP_OKAY);
      @(posedge clk);
      chk("engineOn", 32'(engineOn), 32'h0);
      finalReport;
   end
endmodule
